// ### verilog/uatx_consts.vh
// Offsets, field positions, reset values and timing counts of the async transmitter
`ifndef UATX_CONSTS_VH
`define UATX_CONSTS_VH

// Register word offsets (byte addresses)
`define UATX_ADDR_TXCTL     8'h00
`define UATX_ADDR_RXCTL     8'h04
`define UATX_ADDR_DIVISOR   8'h08
`define UATX_ADDR_TXDATA    8'h0C
`define UATX_ADDR_PINDIR    8'h10
`define UATX_ADDR_POWER     8'h14

// transmit_status_control fields
`define UATX_TXCTL_NINTH_BIT   0
`define UATX_TXCTL_SHIFT_EMPTY 1
`define UATX_TXCTL_HIGH_BAUD   2
`define UATX_TXCTL_SYNC        4
`define UATX_TXCTL_TX_EN       5
`define UATX_TXCTL_NINE_BIT    6
`define UATX_TXCTL_CLK_SRC     7

// receive_status_control fields
`define UATX_RXCTL_PORT_EN     7

// Status word fields (read in TXDATA slot high bits)
`define UATX_STAT_BUF_EMPTY    8
`define UATX_STAT_TX_IE        9

// pin_direction_bits fields
`define UATX_PINDIR_TX         6
`define UATX_PINDIR_RX         7

// Reset values
`define UATX_TXCTL_RESET       8'h02
`define UATX_RXCTL_RESET       8'h00
`define UATX_DIVISOR_RESET     8'h00
`define UATX_PINDIR_RESET      8'hFF

// Prescale: base ticks per bit
`define UATX_PRE_ASYNC_LOW     8'd64
`define UATX_PRE_ASYNC_HIGH    8'd16
`define UATX_PRE_SYNC          8'd4

// Frame shape
`define UATX_FRAME_BITS_8      4'd10
`define UATX_FRAME_BITS_9      4'd11

`endif

// ### verilog/uatx_baud_gen.v
// Baud generator: 8-bit reloading divider plus bit-rate prescaler
`timescale 1ns/1ps
`include "uatx_consts.vh"

module uatx_baud_gen (
   input  wire       clk,
   input  wire       rst,
   input  wire       run,
   input  wire       high_baud_select,
   input  wire       sync_mode,
   input  wire [7:0] divisor,
   output reg        base_tick,
   output reg        bit_tick
);

   reg  [7:0] div_cnt_q;
   reg  [7:0] pre_cnt_q;
   wire [7:0] pre_limit;

   ////////////////////////////////////////////////////////////////////////
   // Prescale selection
   assign pre_limit = sync_mode ? `UATX_PRE_SYNC :
                      (high_baud_select ? `UATX_PRE_ASYNC_HIGH : `UATX_PRE_ASYNC_LOW);

   ////////////////////////////////////////////////////////////////////////
   // Divider reloads from divisor on expiry
   always @(posedge clk) begin
      if (rst || !run) begin
         div_cnt_q <= 8'h00;
         pre_cnt_q <= 8'h00;
         base_tick <= 1'b0;
         bit_tick  <= 1'b0;
      end else begin
         base_tick <= 1'b0;
         bit_tick  <= 1'b0;
         if (div_cnt_q == 8'h00) begin
            div_cnt_q <= divisor;
            base_tick <= 1'b1;
            if (pre_cnt_q >= pre_limit - 8'h01) begin
               pre_cnt_q <= 8'h00;
               bit_tick  <= 1'b1;
            end else begin
               pre_cnt_q <= pre_cnt_q + 8'h01;
            end
         end else begin
            div_cnt_q <= div_cnt_q - 8'h01;
         end
      end
   end

endmodule

// ### verilog/uatx_shifter.v
// Transmit shift register: frames start, data LSB first, optional ninth, stop
`timescale 1ns/1ps
`include "uatx_consts.vh"

module uatx_shifter (
   input  wire       clk,
   input  wire       rst,
   input  wire       load,
   input  wire [8:0] load_data,
   input  wire       load_nine,
   input  wire       bit_tick,
   output reg        busy,
   output reg        done,
   output reg        serial_out
);

   reg [10:0] shreg_q;
   reg [3:0]  count_q;

   always @(posedge clk) begin
      if (rst) begin
         shreg_q    <= 11'h7FF;
         count_q    <= 4'h0;
         busy       <= 1'b0;
         done       <= 1'b0;
         serial_out <= 1'b1;
      end else begin
         done <= 1'b0;
         if (load && !busy) begin
            // Stop, ninth or stop, data, start; shifted from bit 0
            // No parity bit is built; a ninth bit is whatever software wrote
            shreg_q <= load_nine ? {1'b1, load_data[8], load_data[7:0], 1'b0}
                                 : {2'b11, load_data[7:0], 1'b0};
            count_q <= load_nine ? `UATX_FRAME_BITS_9 : `UATX_FRAME_BITS_8;
            busy    <= 1'b1;
         end else if (busy && bit_tick) begin
            serial_out <= shreg_q[0];
            shreg_q    <= {1'b1, shreg_q[10:1]};
            count_q    <= count_q - 4'h1;
            if (count_q == 4'h0) begin
               busy       <= 1'b0;
               done       <= 1'b1;
               serial_out <= 1'b1;
            end
         end
      end
   end

endmodule

// ### verilog/uatx_top.v
// Async transmitter top: Wishbone registers, holding register, pin control
`timescale 1ns/1ps
`include "uatx_consts.vh"

module uatx_top (
   input  wire        clk,
   input  wire        rst,
   input  wire        wb_cyc_i,
   input  wire        wb_stb_i,
   input  wire        wb_we_i,
   input  wire [7:0]  wb_adr_i,
   input  wire [3:0]  wb_sel_i,
   input  wire [31:0] wb_dat_i,
   output reg  [31:0] wb_dat_o,
   output reg         wb_ack_o,
   output wire        wb_err_o,
   input  wire        sleep_req,
   input  wire        tx_clock_pin_i,
   output wire        tx_clock_pin_o,
   output wire        tx_clock_pin_oe,
   input  wire        rx_data_pin_i,
   output wire        rx_data_pin_o,
   output wire        rx_data_pin_oe
);

   ////////////////////////////////////////////////////////////////////////
   // Registers
   reg  [7:0] txctl_q;
   reg  [7:0] rxctl_q;
   reg  [7:0] divisor_q;
   reg  [7:0] pindir_q;
   reg        tx_ie_q;
   reg  [8:0] hold_q;
   reg        hold_full_q;
   reg        sleep_s1_q;
   reg        sleep_s2_q;

   wire port_enable;
   wire transmit_enable;
   wire sync_mode;
   wire async_run;
   wire tx_run;
   wire bit_tick;
   wire sh_busy;
   wire sh_done;
   wire sh_out;
   wire sh_rst;
   wire load;
   wire wb_req;
   wire wr_en;
   wire hit_data;
   wire tx_buffer_empty_flag;
   wire tx_shift_empty;

   function valid_addr;
      input [7:0] a;
      begin
         valid_addr = (a == `UATX_ADDR_TXCTL) || (a == `UATX_ADDR_RXCTL) ||
                      (a == `UATX_ADDR_DIVISOR) || (a == `UATX_ADDR_TXDATA) ||
                      (a == `UATX_ADDR_PINDIR);
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Sleep request synchroniser
   always @(posedge clk) begin
      if (rst) begin
         sleep_s1_q <= 1'b0;
         sleep_s2_q <= 1'b0;
      end else begin
         sleep_s1_q <= sleep_req;
         sleep_s2_q <= sleep_s1_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Mode decode
   assign port_enable     = rxctl_q[`UATX_RXCTL_PORT_EN];
   assign transmit_enable = txctl_q[`UATX_TXCTL_TX_EN];
   assign sync_mode       = txctl_q[`UATX_TXCTL_SYNC];
   assign async_run       = port_enable && !sync_mode && !sleep_s2_q;
   assign tx_run          = async_run && transmit_enable;
   assign sh_rst          = rst || !port_enable || !transmit_enable;

   ////////////////////////////////////////////////////////////////////////
   // Wishbone slave, one-cycle ack
   assign wb_req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wr_en    = wb_req && wb_we_i && wb_sel_i[0];
   assign hit_data = wb_adr_i == `UATX_ADDR_TXDATA;
   assign wb_err_o = 1'b0;

   always @(posedge clk) begin
      if (rst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= wb_req;
         wb_dat_o <= 32'h0000_0000;
         if (wb_req && !wb_we_i && valid_addr(wb_adr_i)) begin
            case (wb_adr_i)
               `UATX_ADDR_TXCTL: begin
                  wb_dat_o[7:0] <= {txctl_q[7:2], tx_shift_empty, txctl_q[0]};
               end
               `UATX_ADDR_RXCTL: begin
                  wb_dat_o[7:0] <= rxctl_q;
               end
               `UATX_ADDR_DIVISOR: begin
                  wb_dat_o[7:0] <= divisor_q;
               end
               `UATX_ADDR_TXDATA: begin
                  wb_dat_o[`UATX_STAT_BUF_EMPTY] <= tx_buffer_empty_flag;
                  wb_dat_o[`UATX_STAT_TX_IE]     <= tx_ie_q;
               end
               `UATX_ADDR_PINDIR: begin
                  wb_dat_o[7:0] <= pindir_q;
               end
               default: begin
                  wb_dat_o <= 32'h0000_0000;
               end
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Control registers stay writable while port is disabled
   always @(posedge clk) begin
      if (rst) begin
         txctl_q   <= `UATX_TXCTL_RESET;
         rxctl_q   <= `UATX_RXCTL_RESET;
         divisor_q <= `UATX_DIVISOR_RESET;
         pindir_q  <= `UATX_PINDIR_RESET;
         tx_ie_q   <= 1'b0;
      end else if (wr_en) begin
         case (wb_adr_i)
            `UATX_ADDR_TXCTL: begin
               txctl_q <= wb_dat_i[7:0];
            end
            `UATX_ADDR_RXCTL: begin
               rxctl_q <= wb_dat_i[7:0];
            end
            `UATX_ADDR_DIVISOR: begin
               divisor_q <= wb_dat_i[7:0];
            end
            `UATX_ADDR_PINDIR: begin
               pindir_q <= wb_dat_i[7:0];
            end
            `UATX_ADDR_TXDATA: begin
               if (wb_sel_i[1]) begin
                  tx_ie_q <= wb_dat_i[`UATX_STAT_TX_IE];
               end
            end
            default: begin
               tx_ie_q <= tx_ie_q;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Holding register; ninth bit captured at write time
   assign load = hold_full_q && !sh_busy && !sh_done && tx_run;

   always @(posedge clk) begin
      if (sh_rst) begin
         hold_full_q <= 1'b0;
         hold_q      <= 9'h000;
      end else begin
         if (wr_en && hit_data) begin
            hold_q      <= {txctl_q[`UATX_TXCTL_NINTH_BIT], wb_dat_i[7:0]};
            hold_full_q <= 1'b1;
         end else if (load) begin
            hold_full_q <= 1'b0;
         end
      end
   end

   // Flag follows enable and empty holding register, whatever tx_ie_q says
   assign tx_buffer_empty_flag = port_enable && transmit_enable && !hold_full_q;
   assign tx_shift_empty       = !sh_busy;

   ////////////////////////////////////////////////////////////////////////
   // Datapath
   uatx_baud_gen u_baud (
      .clk              (clk),
      .rst              (rst),
      .run              (async_run),
      .high_baud_select (txctl_q[`UATX_TXCTL_HIGH_BAUD]),
      .sync_mode        (sync_mode),
      .divisor          (divisor_q),
      .base_tick        (),
      .bit_tick         (bit_tick)
   );

   uatx_shifter u_shift (
      .clk        (clk),
      .rst        (sh_rst),
      .load       (load),
      .load_data  (hold_q),
      .load_nine  (txctl_q[`UATX_TXCTL_NINE_BIT]),
      .bit_tick   (bit_tick && tx_run),
      .busy       (sh_busy),
      .done       (sh_done),
      .serial_out (sh_out)
   );

   ////////////////////////////////////////////////////////////////////////
   // Pins: device drives the TX pin when port and transmitter are enabled and its direction bit is input; RX pin never driven
   assign tx_clock_pin_o  = sh_out;
   assign tx_clock_pin_oe = port_enable && transmit_enable &&
                            pindir_q[`UATX_PINDIR_TX];
   assign rx_data_pin_o   = 1'b1;
   assign rx_data_pin_oe  = 1'b0;

endmodule

// ### tb/uatx_props.sv
// Bus and serial pin checker for the async transmitter
`timescale 1ns/1ps
module uatx_props (
   input wire        clk,
   input wire        rst,
   input wire        wb_cyc_i,
   input wire        wb_stb_i,
   input wire [31:0] wb_dat_o,
   input wire        wb_ack_o,
   input wire        wb_err_o,
   input wire        tx_clock_pin_o,
   input wire        tx_clock_pin_oe,
   input wire        rx_data_pin_o,
   input wire        rx_data_pin_oe
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_bit_held;
      ($stable(tx_clock_pin_o) || !tx_clock_pin_oe) [*8];
   endsequence
   a_ack_follows: assert property (s_req |=> wb_ack_o)
      else $error("no ack after request");
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without request");
   a_err_quiet: assert property (!wb_err_o)
      else $error("error response raised");
   a_reset_state: assert property ($fell(rst) |-> !wb_ack_o && wb_dat_o == 32'h0
      && tx_clock_pin_o && !tx_clock_pin_oe) else $error("outputs not quiet after reset");
   a_bit_held: assert property ((tx_clock_pin_oe && $changed(tx_clock_pin_o)) |=> s_bit_held)
      else $error("serial bit shorter than minimum period");
   a_mark_release: assert property ($fell(tx_clock_pin_oe) |-> ##[0:2] tx_clock_pin_o)
      else $error("line not at mark after release");
   a_rx_pin_input: assert property (!rx_data_pin_oe && rx_data_pin_o)
      else $error("receive pin driven");
endmodule
bind uatx_top uatx_props uatx_props_i (
   .clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
   .tx_clock_pin_o(tx_clock_pin_o), .tx_clock_pin_oe(tx_clock_pin_oe),
   .rx_data_pin_o(rx_data_pin_o), .rx_data_pin_oe(rx_data_pin_oe)
);

// ### tb/uatx_remote_rx.sv
// Remote serial receiver model on the transmit line
`timescale 1ns/1ps
module uatx_remote_rx (
   input  wire        clk,
   input  wire        line,
   input  wire        nine,
   input  int         bit_clks,
   output logic       rx_valid,
   output logic [8:0] rx_word,
   output logic       rx_stop_ok
);
   int i;
   initial begin
      rx_valid = 1'b0;
      rx_word = 9'h000;
      rx_stop_ok = 1'b0;
      forever begin
         @(posedge clk);
         rx_valid <= 1'b0;
         if (line === 1'b0) begin
            rx_word <= 9'h000;
            repeat (bit_clks / 2) @(posedge clk);
            for (i = 0; i < (nine ? 9 : 8); i++) begin
               repeat (bit_clks) @(posedge clk);
               rx_word[i] <= line;
            end
            repeat (bit_clks) @(posedge clk);
            rx_stop_ok <= (line === 1'b1);
            rx_valid <= 1'b1;
         end
      end
   end
endmodule

// ### tb/tb_top.sv
// Self-checking bench for the async transmitter
`timescale 1ns/1ps
module tb_top;
   logic        clk, rst, wb_cyc, wb_stb, wb_we, sleep_req, nine;
   logic [7:0]  wb_adr;
   logic [3:0]  wb_sel;
   logic [31:0] wb_dat, q, seed;
   wire  [31:0] wb_dat_o;
   wire         wb_ack_o, wb_err_o, tx_o, tx_oe, rx_o, rx_oe, rx_valid, rx_stop_ok;
   wire  [8:0]  rx_word;
   wire         line = tx_oe ? tx_o : 1'b1;
   int          bit_clks, error_cnt, cmp_count, cycles, i, k;
   logic [8:0]  exp_q[$], got_q[$];
   logic [7:0]  adr_t[6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h20};
   logic [31:0] rst_t[6] = '{32'h02, 32'h00, 32'h00, 32'h00, 32'hFF, 32'h00};
   uatx_top uatx_top_i (.clk(clk), .rst(rst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
      .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .sleep_req(sleep_req),
      .tx_clock_pin_i(1'b1), .tx_clock_pin_o(tx_o), .tx_clock_pin_oe(tx_oe),
      .rx_data_pin_i(1'b1), .rx_data_pin_o(rx_o), .rx_data_pin_oe(rx_oe));
   uatx_remote_rx uatx_remote_rx_i (.clk(clk), .line(line), .nine(nine), .bit_clks(bit_clks),
      .rx_valid(rx_valid), .rx_word(rx_word), .rx_stop_ok(rx_stop_ok));
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction
   task final_report;
      if (error_cnt == 0 && cmp_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task xfer(input logic we, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= a;
      wb_dat <= d;
      @(posedge clk);
      while (wb_ack_o !== 1'b1) @(posedge clk);
      q = wb_dat_o;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
   endtask
   task send(input logic nb);
      seed = xs(seed);
      exp_q.push_back({nb, seed[7:0]});
      xfer(1'b1, 8'h0C, {24'h0, seed[7:0]});
   endtask
   task drain;
      while (got_q.size() < exp_q.size()) @(posedge clk);
      while (exp_q.size() > 0) check("rx_word", got_q.pop_front(), exp_q.pop_front());
      repeat (bit_clks) @(posedge clk);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (rx_valid === 1'b1) begin
         got_q.push_back(rx_word);
         check("stop_bit", rx_stop_ok, 1'b1);
      end
      if (cycles > 40000) begin
         error_cnt++;
         final_report();
      end
   end
   initial begin
      {rst, wb_cyc, wb_stb, wb_we, sleep_req, nine} = 6'b100000;
      {wb_adr, wb_sel, wb_dat} = {8'h00, 4'hF, 32'h0};
      seed = 32'hB807;
      bit_clks = 16;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      for (i = 0; i < 6; i++) begin
         xfer(1'b0, adr_t[i], 32'h0);
         check("reset_value", q, rst_t[i]);
      end
      xfer(1'b1, 8'h00, 32'h24);
      xfer(1'b0, 8'h00, 32'h0);
      check("txctl_preset", q, 32'h26);
      xfer(1'b0, 8'h0C, 32'h0);
      check("flag_port_off", q[8], 1'b0);
      xfer(1'b1, 8'h04, 32'h80);
      xfer(1'b0, 8'h0C, 32'h0);
      check("flag_enable", q[8], 1'b1);
      check("tx_oe", tx_oe, 1'b1);
      send(1'b0);
      send(1'b0);
      xfer(1'b0, 8'h0C, 32'h0);
      check("flag_full", q[8], 1'b0);
      xfer(1'b0, 8'h00, 32'h0);
      check("shift_busy", q[1], 1'b0);
      drain();
      xfer(1'b0, 8'h00, 32'h0);
      check("shift_idle", q[1], 1'b1);
      check("idle_line", tx_o, 1'b1);
      nine = 1'b1;
      for (k = 0; k < 2; k++) begin
         xfer(1'b1, 8'h00, 32'h64 | k);
         send(k[0]);
         drain();
      end
      nine = 1'b0;
      for (k = 0; k < 2; k++) begin
         xfer(1'b1, 8'h04, 32'h00);
         xfer(1'b1, 8'h08, 32'h01 - k);
         xfer(1'b1, 8'h00, k ? 32'h24 : 32'h20);
         xfer(1'b1, 8'h04, 32'h80);
         bit_clks = k ? 16 : 128;
         send(1'b0);
         drain();
      end
      sleep_req <= 1'b1;
      send(1'b0);
      repeat (300) @(posedge clk);
      check("sleep_line", line, 1'b1);
      sleep_req <= 1'b0;
      drain();
      xfer(1'b1, 8'h0C, 32'h5A);
      repeat (40) @(posedge clk);
      xfer(1'b1, 8'h00, 32'h04);
      check("abort_oe", tx_oe, 1'b0);
      xfer(1'b0, 8'h00, 32'h0);
      check("abort_txctl", q, 32'h06);
      repeat (400) @(posedge clk);
      got_q.delete();
      xfer(1'b1, 8'h00, 32'h24);
      send(1'b0);
      drain();
      final_report();
   end
endmodule
